// ===== inc/sst_pkg.sv
// How it works
// - software picks one 32-bit counter or two 16-bit halves
// - each counter advances on system clock or a selected input edge
// - count up only, or up then down
// - a state variable survives counter cycles
// - events combine match, input/output condition, state and direction
// - only events change outputs, interrupt and state
// - match slot 0 may act as automatic counter limit
// - events may be qualified by count direction
// - a match may be held pending until a qualifying condition
// - selected events limit, halt, start or stop a counter
// - all interrupt sources merge into one interrupt line
// - counting logic runs from the system clock
// - split halves keep own count, state, controls and slot values
// - clock choice, inputs, events, outputs and interrupt stay shared
// - events may use matches of either half
// - with join set, each slot half pair acts as one word
// - with join clear, halves are written together or separately
// - slot function bit picks match/reload or capture
// - a capture event stores the count for software to read
package sst_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 4;
  localparam int NUM_SLOT = 5;
  localparam int NUM_EV = 6;
  localparam int CNT_W = 32;
  localparam int LIMIT_SLOT = 0;
  localparam logic [1:0] IO_LOW = 2'h0;
  localparam logic [1:0] IO_RISE = 2'h1;
  localparam logic [1:0] IO_FALL = 2'h2;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;
  localparam logic [1:0] HALT_RST = 2'h3;
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [1:0] STATE_RST = 2'h0;
  localparam logic [3:0] OUT_RST = 4'h0;
  localparam logic [31:0] COUNT_RST = 32'h0;

  typedef enum logic [1:0] {
    COMB_OR = 2'h0,
    COMB_MATCH = 2'h1,
    COMB_IO = 2'h2,
    COMB_AND = 2'h3
  } comb_t;

  typedef struct packed {
    logic [2:0] match_sel;
    logic upper;
    logic hold;
    logic [2:0] io_sel;
    logic [1:0] io_cond;
    comb_t comb;
    logic [1:0] state_mask;
    logic [1:0] dir_cond;
    logic [3:0] set_out;
    logic [3:0] clr_out;
    logic irq_en;
    logic state_ld;
    logic state_val;
  } event_cfg_t;

  typedef struct packed {
    logic [5:0] limit;
    logic [5:0] halt;
    logic [5:0] stop;
    logic [5:0] start;
  } half_ctl_t;

  typedef struct packed {
    logic [1:0] halt;
    logic [1:0] stop;
    logic [1:0] clear;
  } run_ctl_t;
endpackage

// ===== design/sst_input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sst_input_sync #(
  parameter int N = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [N-1:0] i_pin,
  output logic [N-1:0] o_level,
  output logic [N-1:0] o_rise,
  output logic [N-1:0] o_fall
);
  typedef struct packed {
    logic [N-1:0] ff1;
    logic [N-1:0] ff2;
    logic [N-1:0] ff3;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
  } sync_t;
  sync_t s_q, s_d;

  if (N < 1) begin : g_chk
    $error("sst_input_sync needs N >= 1");
  end

  // ***********************************
  // three stages, change once 2 and 3 agree
  // ***********************************
  always_comb begin
    s_d = s_q;
    s_d.ff1 = i_pin;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    s_d.lvl = (s_q.lvl & (s_q.ff2 ^ s_q.ff3)) | (s_q.ff3 & (s_q.ff2 ~^ s_q.ff3));
    s_d.rise = s_d.lvl & ~s_q.lvl;
    s_d.fall = ~s_d.lvl & s_q.lvl;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.lvl;
  assign o_rise = s_q.rise;
  assign o_fall = s_q.fall;

  a_sync_agree: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_q.ff2[0] != s_q.ff3[0]) |=> (s_q.lvl[0] == $past(s_q.lvl[0])))
    else $error("level moved while sync stages disagreed");
endmodule
`default_nettype wire

// ===== design/sst_slot_bank.sv
`timescale 1ns/1ps
`default_nettype none
module sst_slot_bank #(
  parameter int SLOTS = 5,
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_counter_join,
  input wire logic [SLOTS-1:0] i_slot_function,
  input wire logic i_reload_wr,
  input wire logic [2:0] i_reload_idx,
  input wire logic [1:0] i_reload_half,
  input wire logic [W-1:0] i_reload_data,
  input wire logic [1:0] i_halted,
  input wire logic [1:0] i_reload_now,
  input wire logic [SLOTS-1:0] i_cap_en,
  input wire logic [W-1:0] i_count,
  input wire logic [2:0] i_rd_idx,
  output logic [SLOTS-1:0][W-1:0] o_match,
  output logic [W-1:0] o_rd_data
);
  localparam int H = W / 2;
  typedef struct packed {
    logic [SLOTS-1:0][W-1:0] val;
    logic [SLOTS-1:0][W-1:0] rld;
    logic [W-1:0] rd;
  } bank_t;
  bank_t b_q, b_d;
  logic [1:0] hm;

  if ((W % 2) != 0 || SLOTS > 8 || SLOTS < 1) begin : g_chk
    $error("sst_slot_bank needs even W and 1..8 slots");
  end

  // ***********************************
  // match/reload or capture storage
  // ***********************************
  always_comb begin
    b_d = b_q;
    hm = i_counter_join ? 2'h3 : i_reload_half;
    for (int i = 0; i < SLOTS; i++) begin
      if (i_reload_wr && i_reload_idx == 3'(i)) begin
        if (hm[0]) begin
          b_d.rld[i][H-1:0] = i_reload_data[H-1:0];
        end
        if (hm[1]) begin
          b_d.rld[i][W-1:H] = i_reload_data[W-1:H];
        end
      end
      if (i_slot_function[i]) begin
        if (i_reload_now[0] || i_halted[0]) begin
          b_d.val[i][H-1:0] = b_d.rld[i][H-1:0];
        end
        if (i_reload_now[1] || i_halted[1]) begin
          b_d.val[i][W-1:H] = b_d.rld[i][W-1:H];
        end
      end else if (i_cap_en[i]) begin
        b_d.val[i] = i_count;
      end
    end
    b_d.rd = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (i_rd_idx == 3'(i)) begin
        b_d.rd = b_q.val[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign o_match = b_q.val;
  assign o_rd_data = b_q.rd;

  a_capture_store: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_slot_function[0] && i_cap_en[0]) |=> (b_q.val[0] == $past(i_count)))
    else $error("capture did not store the count");
  a_reload_match: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_slot_function[0] && i_reload_now == 2'h3 && !i_reload_wr) |=> (b_q.val[0] == b_q.rld[0]))
    else $error("match not reloaded at limit");
endmodule
`default_nettype wire

// ===== design/sst_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sst_timer #(
  parameter int NUM_EV = sst_pkg::NUM_EV,
  parameter int NUM_SLOT = sst_pkg::NUM_SLOT
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_counter_join,
  input wire logic i_clk_from_input,
  input wire logic [1:0] i_clk_input_idx,
  input wire logic [1:0] i_bidir,
  input wire logic [1:0] i_auto_limit,
  input wire logic [4:0] i_slot_function,
  input wire sst_pkg::event_cfg_t [5:0] i_event_cfg,
  input wire sst_pkg::half_ctl_t [1:0] i_half_ctl,
  input wire logic [4:0][5:0] i_capture_ev,
  input wire logic i_run_wr,
  input wire sst_pkg::run_ctl_t i_run_data,
  input wire logic i_reload_wr,
  input wire logic [2:0] i_reload_idx,
  input wire logic [1:0] i_reload_half,
  input wire logic [31:0] i_reload_data,
  input wire logic [2:0] i_cap_rd_idx,
  input wire logic [3:0] i_timer_input,
  output logic [3:0] o_timer_output,
  output logic o_irq,
  output logic [31:0] o_count,
  output logic [1:0] o_state,
  output logic [1:0] o_dir,
  output logic [1:0] o_halted,
  output logic [1:0] o_stopped,
  output logic [5:0] o_event_fired,
  output logic [31:0] o_cap_rd_data
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [1:0] dir;
    logic [1:0] st;
    logic [1:0] halt;
    logic [1:0] stop;
    logic [3:0] outs;
    logic irq;
    logic [5:0] pend;
    logic [5:0] fired;
  } core_t;
  core_t c_q, c_d;

  logic [3:0] in_lvl, in_rise, in_fall;
  logic [4:0][31:0] mval;
  logic [4:0] m_lo, m_hi, cap_en;
  logic [5:0] fire;
  logic [1:0] lim, live, run, rl_now;
  logic tick, any_fire, irq_any;

  if (NUM_EV != sst_pkg::NUM_EV || NUM_SLOT != sst_pkg::NUM_SLOT) begin : g_chk
    $error("sst_timer supports exactly six events and five slots");
  end

  // ***********************************
  // helpers
  // ***********************************
  function automatic logic pick5(input logic [4:0] m, input logic [2:0] sel);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (sel == 3'(i)) begin
        r = m[i];
      end
    end
    return r;
  endfunction

  function automatic logic io_hit(input logic [2:0] sel, input logic [1:0] cond,
                                  input logic [3:0] lvl, input logic [3:0] rs,
                                  input logic [3:0] fl, input logic [3:0] outs);
    logic r;
    r = 1'b0;
    if (sel[2]) begin
      r = cond[0] ? outs[sel[1:0]] : ~outs[sel[1:0]];
    end else begin
      unique case (cond)
        sst_pkg::IO_LOW: r = ~lvl[sel[1:0]];
        sst_pkg::IO_RISE: r = rs[sel[1:0]];
        sst_pkg::IO_FALL: r = fl[sel[1:0]];
        default: r = lvl[sel[1:0]];
      endcase
    end
    return r;
  endfunction

  // returns {dir, count}; narrow halves wrap by truncation
  function automatic logic [32:0] step(input logic [31:0] c, input logic dn,
                                       input logic lm, input logic bd);
    logic [32:0] r;
    r = {dn, c};
    if (!dn) begin
      if (lm) begin
        r = bd ? {1'b1, c - 32'h1} : {1'b0, 32'h0};
      end else begin
        r = {1'b0, c + 32'h1};
      end
    end else if (c == 32'h0) begin
      r = {1'b0, c + 32'h1};
    end else begin
      r = {1'b1, c - 32'h1};
    end
    return r;
  endfunction

  // ***********************************
  // submodules
  // ***********************************
  sst_input_sync #(
    .N(sst_pkg::NUM_IN)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_pin(i_timer_input),
    .o_level(in_lvl),
    .o_rise(in_rise),
    .o_fall(in_fall)
  );

  sst_slot_bank #(
    .SLOTS(sst_pkg::NUM_SLOT),
    .W(sst_pkg::CNT_W)
  ) u_bank (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_counter_join(i_counter_join),
    .i_slot_function(i_slot_function),
    .i_reload_wr(i_reload_wr),
    .i_reload_idx(i_reload_idx),
    .i_reload_half(i_reload_half),
    .i_reload_data(i_reload_data),
    .i_halted(c_q.halt),
    .i_reload_now(rl_now),
    .i_cap_en(cap_en),
    .i_count(c_q.cnt),
    .i_rd_idx(i_cap_rd_idx),
    .o_match(mval),
    .o_rd_data(o_cap_rd_data)
  );

  // ***********************************
  // match, events and counting
  // ***********************************
  always_comb begin
    logic [32:0] s32, s_lo, s_hi;
    logic [3:0] set_all, clr_all;
    logic [5:0] irq_v;
    logic [1:0] lim_ev, halt_ev, stop_ev, start_ev;
    logic hs, mt, mterm, io, q, cmb;
    sst_pkg::event_cfg_t c;
    c_d = c_q;
    hs = 1'b0;
    mt = 1'b0;
    mterm = 1'b0;
    io = 1'b0;
    q = 1'b0;
    cmb = 1'b0;
    c = '0;
    s32 = '0;
    s_lo = '0;
    s_hi = '0;
    set_all = '0;
    clr_all = '0;
    irq_v = '0;
    lim_ev = '0;
    halt_ev = '0;
    stop_ev = '0;
    start_ev = '0;
    fire = '0;
    cap_en = '0;
    rl_now = '0;
    tick = i_clk_from_input ? in_rise[i_clk_input_idx] : 1'b1;
    live = {i_counter_join ? ~c_q.halt[0] : ~c_q.halt[1], ~c_q.halt[0]} & {2{tick}};
    run = live & ~(i_counter_join ? {2{c_q.stop[0]}} : c_q.stop);
    for (int i = 0; i < 5; i++) begin
      m_lo[i] = i_slot_function[i] & (i_counter_join ? mval[i] == c_q.cnt
                                      : mval[i][15:0] == c_q.cnt[15:0]);
      m_hi[i] = i_slot_function[i] & (mval[i][31:16] == c_q.cnt[31:16]);
    end
    for (int e = 0; e < 6; e++) begin
      c = i_event_cfg[e];
      hs = c.upper & ~i_counter_join;
      mt = pick5(hs ? m_hi : m_lo, c.match_sel);
      mterm = mt | (c.hold & c_q.pend[e]);
      io = io_hit(c.io_sel, c.io_cond, in_lvl, in_rise, in_fall, c_q.outs);
      q = c.state_mask[c_q.st[hs]] & live[hs];
      if (i_bidir[hs] && c.dir_cond == sst_pkg::DIR_UP) begin
        q = q & ~c_q.dir[hs];
      end
      if (i_bidir[hs] && c.dir_cond == sst_pkg::DIR_DOWN) begin
        q = q & c_q.dir[hs];
      end
      unique case (c.comb)
        sst_pkg::COMB_OR: cmb = mterm | io;
        sst_pkg::COMB_MATCH: cmb = mterm;
        sst_pkg::COMB_IO: cmb = io;
        default: cmb = mterm & io;
      endcase
      fire[e] = q & cmb;
      c_d.pend[e] = c.hold & (c_q.pend[e] | (mt & live[hs])) & ~fire[e];
      if (fire[e]) begin
        set_all = set_all | c.set_out;
        clr_all = clr_all | c.clr_out;
        irq_v[e] = c.irq_en;
        if (c.state_ld) begin
          c_d.st[hs] = c.state_val;
          if (i_counter_join) begin
            c_d.st = {2{c.state_val}};
          end
        end
      end
    end
    for (int i = 0; i < 5; i++) begin
      cap_en[i] = ~i_slot_function[i] & |(fire & i_capture_ev[i]);
    end
    for (int h = 0; h < 2; h++) begin
      lim_ev[h] = |(fire & i_half_ctl[h].limit);
      halt_ev[h] = |(fire & i_half_ctl[h].halt);
      stop_ev[h] = |(fire & i_half_ctl[h].stop);
      start_ev[h] = |(fire & i_half_ctl[h].start);
    end
    lim[0] = lim_ev[0] | (i_auto_limit[0] & m_lo[sst_pkg::LIMIT_SLOT]);
    lim[1] = lim_ev[1] | (i_auto_limit[1] & m_hi[sst_pkg::LIMIT_SLOT]);
    if (i_counter_join) begin
      s32 = step(c_q.cnt, c_q.dir[0], lim[0], i_bidir[0]);
      if (run[0]) begin
        c_d.cnt = s32[31:0];
        c_d.dir = {2{s32[32]}};
        rl_now = {2{lim[0]}};
      end
      c_d.halt = {2{c_q.halt[0] | halt_ev[0]}};
      c_d.stop = {2{(c_q.stop[0] & ~start_ev[0]) | stop_ev[0]}};
    end else begin
      s_lo = step({16'h0, c_q.cnt[15:0]}, c_q.dir[0], lim[0], i_bidir[0]);
      s_hi = step({16'h0, c_q.cnt[31:16]}, c_q.dir[1], lim[1], i_bidir[1]);
      if (run[0]) begin
        c_d.cnt[15:0] = s_lo[15:0];
        c_d.dir[0] = s_lo[32];
        rl_now[0] = lim[0];
      end
      if (run[1]) begin
        c_d.cnt[31:16] = s_hi[15:0];
        c_d.dir[1] = s_hi[32];
        rl_now[1] = lim[1];
      end
      c_d.halt = c_q.halt | halt_ev;
      c_d.stop = (c_q.stop & ~start_ev) | stop_ev;
    end
    if (i_run_wr) begin
      c_d.halt = i_counter_join ? {2{i_run_data.halt[0]}} : i_run_data.halt;
      c_d.stop = i_counter_join ? {2{i_run_data.stop[0]}} : i_run_data.stop;
      if (i_run_data.clear[0]) begin
        c_d.cnt[15:0] = 16'h0;
        c_d.dir[0] = 1'b0;
      end
      if (i_counter_join ? i_run_data.clear[0] : i_run_data.clear[1]) begin
        c_d.cnt[31:16] = 16'h0;
        c_d.dir[1] = 1'b0;
      end
    end
    c_d.outs = (c_q.outs & ~clr_all) | set_all;
    c_d.irq = |irq_v;
    c_d.fired = fire;
  end

  assign any_fire = |fire;
  assign irq_any = |(fire & {i_event_cfg[5].irq_en, i_event_cfg[4].irq_en, i_event_cfg[3].irq_en,
                             i_event_cfg[2].irq_en, i_event_cfg[1].irq_en, i_event_cfg[0].irq_en});

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      c_q <= '0;
      c_q.cnt <= sst_pkg::COUNT_RST;
      c_q.st <= sst_pkg::STATE_RST;
      c_q.halt <= sst_pkg::HALT_RST;
      c_q.stop <= sst_pkg::STOP_RST;
      c_q.outs <= sst_pkg::OUT_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign o_timer_output = c_q.outs;
  assign o_irq = c_q.irq;
  assign o_count = c_q.cnt;
  assign o_state = c_q.st;
  assign o_dir = c_q.dir;
  assign o_halted = c_q.halt;
  assign o_stopped = c_q.stop;
  assign o_event_fired = c_q.fired;

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  a_halt_freezes: assert property (c_q.halt[0] && i_counter_join && !i_run_wr |=> $stable(c_q.cnt))
    else $error("count moved while halted");
  a_limit_wrap: assert property (i_counter_join && run[0] && lim[0] && !i_bidir[0] && !c_q.dir[0]
    && !i_run_wr |=> c_q.cnt == 32'h0)
    else $error("count did not wrap at limit");
  a_bidir_turn: assert property (i_counter_join && run[0] && lim[0] && i_bidir[0] && !c_q.dir[0]
    && !i_run_wr |=> c_q.dir[0])
    else $error("direction did not turn at limit");
  a_count_step: assert property (i_counter_join && run[0] && !lim[0] && !c_q.dir[0] && !i_run_wr
    |=> c_q.cnt == $past(c_q.cnt) + 32'h1)
    else $error("count did not advance by one");
  a_half_apart: assert property (!i_counter_join && c_q.halt[0] && !i_run_wr
    |=> c_q.cnt[15:0] == $past(c_q.cnt[15:0]))
    else $error("halted low half moved");
  a_out_by_event: assert property (!any_fire |=> o_timer_output == $past(o_timer_output))
    else $error("output changed without event");
  a_irq_merge: assert property (##1 (o_irq == $past(irq_any)))
    else $error("interrupt line not the merge of events");
  a_state_hold: assert property (!any_fire |=> $stable(o_state))
    else $error("state changed without event");
  a_stop_holds: assert property (i_counter_join && c_q.stop[0] && !i_run_wr
    |=> $stable(c_q.cnt))
    else $error("count moved while stopped");

  c_limit_wrap: cover property (run[0] && lim[0] && i_counter_join);
  c_capture: cover property (|cap_en);
  c_state_move: cover property (o_state != $past(o_state));
  c_split_run: cover property (!i_counter_join && run == 2'h3);
endmodule
`default_nettype wire

// ===== tb/sst_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pin side model: drives the timer inputs
// ****************************************
module sst_pin_model (
  input wire logic i_clk_sys,
  output logic [3:0] o_pins
);
  initial o_pins = 4'h0;
  // level change just after an edge, held for the synchroniser
  task automatic set_pin(input int idx, input logic v);
    @(posedge i_clk_sys);
    #1;
    o_pins[idx] = v;
  endtask
  // one clean pulse, three cycles high and three low
  task automatic pulse(input int idx);
    set_pin(idx, 1'b1);
    repeat (2) @(posedge i_clk_sys);
    set_pin(idx, 1'b0);
    repeat (3) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== tb/sst_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sst_timer_tb;
  logic clk, rst, join_c, cfi, run_wr, rl_wr, irq;
  logic [1:0] cidx, bidir, alim, st, dir, hlt, stp, rl_half;
  logic [4:0] sfn;
  logic [2:0] rl_idx, rd_idx;
  logic [31:0] rl_data, cnt_o, cap_o;
  logic [4:0][5:0] cap_ev;
  sst_pkg::event_cfg_t [5:0] ev;
  sst_pkg::half_ctl_t [1:0] hc;
  sst_pkg::run_ctl_t run_d;
  logic [3:0] pins, outs;
  logic [5:0] fired;
  int mismatches, checks_done, i, b, k, m, lim, n_irq;
  integer seed = 32'h8073;
  logic [31:0] prev;
  logic down_seen;

  sst_pin_model u_pins (.i_clk_sys(clk), .o_pins(pins));
  sst_timer u_dut (.i_clk_sys(clk), .i_reset(rst), .i_counter_join(join_c), .i_clk_from_input(cfi),
    .i_clk_input_idx(cidx), .i_bidir(bidir), .i_auto_limit(alim), .i_slot_function(sfn), .i_event_cfg(ev),
    .i_half_ctl(hc), .i_capture_ev(cap_ev), .i_run_wr(run_wr), .i_run_data(run_d), .i_reload_wr(rl_wr),
    .i_reload_idx(rl_idx), .i_reload_half(rl_half), .i_reload_data(rl_data), .i_cap_rd_idx(rd_idx),
    .i_timer_input(pins), .o_timer_output(outs), .o_irq(irq), .o_count(cnt_o), .o_state(st), .o_dir(dir),
    .o_halted(hlt), .o_stopped(stp), .o_event_fired(fired), .o_cap_rd_data(cap_o));

  // ****************************************
  // clock, helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input logic [1:0] h, input logic [1:0] c);
    run_d = '{halt: h, stop: 2'h0, clear: c};
    run_wr = 1'b1;
    tick(1);
    run_wr = 1'b0;
  endtask
  task automatic reload(input logic [2:0] idx, input logic [31:0] d);
    rl_idx = idx;
    rl_data = d;
    rl_wr = 1'b1;
    tick(1);
    rl_wr = 1'b0;
    tick(2);
  endtask
  task automatic reset_chk();
    chk("halted", hlt, 32'h3);
    chk("count", cnt_o, 32'h0);
    chk("outputs", outs, 32'h0);
    chk("state", st, 32'h0);
    chk("stopped", stp, 32'h0);
  endtask
  function automatic logic step_ok(input logic [31:0] p, input logic [31:0] c, input int l, input int bd);
    if (c > l) return 1'b0;
    if (bd == 0) return c == ((p == l) ? 32'h0 : p + 1);
    return (c == p + 1) || (c + 1 == p);
  endfunction

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1; join_c = 1'b1; cfi = 1'b0; cidx = 2'h0; bidir = 2'h0; alim = 2'h0; sfn = 5'h1F;
    rl_half = 2'h3;
    ev = '0; hc = '0; cap_ev = '0; run_wr = 1'b0; run_d = '0; rl_wr = 1'b0; rl_idx = 3'h0;
    rl_data = 32'h0; rd_idx = 3'h0; mismatches = 0; checks_done = 0;
    tick(16);
    rst = 1'b0;
    tick(1);
    reset_chk();
    // limit by slot 0, up and up-down
    for (b = 0; b < 2; b++) begin
      lim = 3 + ($random(seed) & 7);
      run(2'h3, 2'h3);
      reload(3'h0, lim);
      alim = 2'h1;
      bidir = b[1:0];
      run(2'h0, 2'h3);
      tick(2);
      prev = cnt_o;
      down_seen = 1'b0;
      for (i = 0; i < 3 * lim; i++) begin
        tick(1);
        chk("count_step", 32'(step_ok(prev, cnt_o, lim, b)), 32'h1);
        if (dir[0] === 1'b1) down_seen = 1'b1;
        prev = cnt_o;
      end
      chk("down_seen", 32'(down_seen), b);
    end
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    reset_chk();
    // match event sets output, raises irq, loads state, halts
    m = 2 + ($random(seed) & 7);
    reload(3'h0, 32'd20);
    reload(3'h1, m);
    ev[0] = '{match_sel: 3'h1, comb: sst_pkg::COMB_MATCH, state_mask: 2'h3, set_out: 4'h1, irq_en: 1'b1,
      state_ld: 1'b1, state_val: 1'b1, default: '0};
    hc[0].halt = 6'h01;
    bidir = 2'h0;
    run(2'h0, 2'h3);
    n_irq = 0;
    for (i = 0; i < 60 && hlt[0] !== 1'b1; i++) begin
      tick(1);
      if (irq === 1'b1) n_irq++;
      if (irq === 1'b1) chk("fired_with_irq", fired, 32'h1);
    end
    tick(3);
    chk("ev_halt", hlt[0], 32'h1);
    chk("ev_out", outs, 32'h1);
    chk("ev_irq", n_irq, 32'h1);
    chk("ev_state", st[0], 32'h1);
    chk("halt_cnt", 32'(cnt_o == m || cnt_o == m + 1), 32'h1);
    // capture on input level, counting on input edges
    ev = '0;
    hc = '0;
    reload(3'h0, 32'd100);
    sfn = 5'h1B;
    cfi = 1'b1;
    cidx = 2'h0;
    ev[1] = '{match_sel: 3'h7, io_sel: 3'h1, io_cond: 2'h3, comb: sst_pkg::COMB_IO, state_mask: 2'h3, default: '0};
    cap_ev[2] = 6'h02;
    for (b = 0; b < 4; b++) begin
      k = 1 + ($random(seed) & 7);
      run(2'h0, 2'h3);
      tick(2);
      for (i = 0; i < k; i++) u_pins.pulse(0);
      u_pins.set_pin(1, 1'b1);
      tick(6);
      u_pins.pulse(0);
      u_pins.set_pin(1, 1'b0);
      tick(6);
      rd_idx = 3'h2;
      tick(2);
      chk("capture", cap_o, k);
      chk("in_count", cnt_o, k + 1);
    end
    rd_idx = 3'h5;
    tick(2);
    chk("cap_none", cap_o, 32'h0);
    // split halves run and halt apart
    ev = '0;
    cfi = 1'b0;
    alim = 2'h0;
    join_c = 1'b0;
    run(2'h2, 2'h3);
    tick(10);
    chk("split_halt", hlt, 32'h2);
    chk("split_hi", cnt_o[31:16], 32'h0);
    chk("split_lo", 32'(cnt_o[15:0] >= 8 && cnt_o[15:0] <= 11), 32'h1);
    prev = cnt_o;
    run(2'h1, 2'h0);
    tick(5);
    chk("lo_frozen", cnt_o[15:0], prev[15:0] + 1);
    chk("hi_runs", 32'(cnt_o[31:16] >= 3 && cnt_o[31:16] <= 6), 32'h1);
    // low half written alone while both halves halted
    rl_half = 2'h1;
    run(2'h3, 2'h0);
    reload(3'h3, 32'hABCD1234);
    rd_idx = 3'h3;
    tick(2);
    chk("half_write", cap_o, 32'h00001234);
    close_out();
  end
endmodule
`default_nettype wire
